// ==== hw/ptp_corr_pkg.sv ====
// constants for the transmit correction-delay control block
// assumes a single transmit clock domain and an apb3 register master
package ptp_corr_pkg;
   // ***********************************************************
   // widths
   // ***********************************************************
   localparam int DELAY_W = 32;
   localparam int IDX_W = 7;
   localparam int SLOTS = 2;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   // ***********************************************************
   // register offsets (byte addresses)
   // ***********************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TBL_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_TBL_ASYM = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_TBL_P2P = 8'h10;
   // ***********************************************************
   // field positions and reset values
   // ***********************************************************
   localparam int CTRL_SEG_BIT = 0;
   localparam int CTRL_EN_BIT = 1;
   localparam int STATUS_VIOL_BIT = 0;
   localparam int STATUS_IDX_LSB = 8;
   localparam int STATUS_CNT_LSB = 16;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [IDX_W-1:0] TBL_ADDR_RST = 7'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   // ***********************************************************
   // cycle counts
   // ***********************************************************
   localparam int PIPE_LAT = 2;
endpackage

// ==== hw/delay_table_mem.sv ====
// delay lookup table: one write port, one registered read port per slot
// assumes writes and reads share the transmit clock
`timescale 1ns/1ns
module delay_table_mem
   import ptp_corr_pkg::*;
#(
   parameter int DW = DELAY_W,
   parameter int AW = IDX_W,
   parameter int NRD = SLOTS
) (
   input wire logic pclk,
   input wire logic ce,
   input wire logic [AW-1:0] waddr,
   input wire logic [1:0] we,
   input wire logic [DW-1:0] wdata,
   input wire logic [NRD*AW-1:0] raddr,
   output logic [NRD*2*DW-1:0] rdata
);
   // entry layout {asym, p2p}; we[1] writes asym, we[0] writes p2p
   logic [DW-1:0] asym_mem [2**AW];
   logic [DW-1:0] p2p_mem [2**AW];

   always_ff @(posedge pclk) begin
      if (ce && we[1]) begin
         asym_mem[waddr] <= wdata;
      end
      if (ce && we[0]) begin
         p2p_mem[waddr] <= wdata;
      end
   end

   for (genvar p = 0; p < NRD; p++) begin : g_rd
      always_ff @(posedge pclk) begin
         if (ce) begin
            rdata[p*2*DW +: 2*DW] <= {asym_mem[raddr[p*AW +: AW]],
                                      p2p_mem[raddr[p*AW +: AW]]};
         end
      end
   end
endmodule

// ==== hw/ptp_corr_ctl.sv ====
// transmit correction-delay controls: samples per-packet delay requests
// at start of packet and emits the signed correction increment per slot
// assumes all client inputs come from logic on pclk; apb3 register slave
// Functional notes
// [R1] peer delay request adds the table's mean path delay to the packet
// [R2] asymmetry request adds the table's asymmetry delay; one bit per slot
// [R3] sign bit zero adds asymmetry delay, one subtracts it
// [R4] seven-bit index per slot selects the table entry used
// [R5] software loads table entries before packets refer to them
// [R6] streaming peer request sampled only with valid and start of packet
// [R7] segmented peer request bit per half, sampled on that half's start
// [R8] client never requests corrections when skip-crc is set
// [R9] streaming asymmetry request sampled only with valid and start
// [R10] segmented asymmetry request bit per half, sampled on that start
// [R11] sign bit per slot sampled with its qualified start of packet
// [R12] index bits 6:0 with first start, 13:7 with second half start
// [R13] controls captured at qualifying start and ignored otherwise
`timescale 1ns/1ns
module ptp_corr_ctl
   import ptp_corr_pkg::*;
#(
   parameter int DW = DELAY_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_valid,
   input wire logic tx_startofpacket,
   input wire logic tx_mac_valid,
   input wire logic [15:0] tx_mac_inframe,
   input wire logic tx_skip_crc,
   input wire logic [SLOTS-1:0] peer_delay_add_req,
   input wire logic [SLOTS-1:0] asym_delay_add_req,
   input wire logic [SLOTS-1:0] asym_delay_sign,
   input wire logic [SLOTS*IDX_W-1:0] delay_table_index,
   output logic [SLOTS-1:0] corr_valid,
   output logic [SLOTS*(DW+2)-1:0] corr_delta
);
   localparam int DW2 = DW + 2;

   // ***********************************************************
   // register state
   // ***********************************************************
   logic [1:0] ctrl_r;
   logic [IDX_W-1:0] tbl_addr_r;
   logic viol_r;
   logic [IDX_W-1:0] last_idx_r;
   logic [CNT_W-1:0] pkt_cnt_r;
   logic seg_mode;
   logic enable;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_nxt;
   logic err_nxt;

   assign seg_mode = ctrl_r[CTRL_SEG_BIT];
   assign enable = ctrl_r[CTRL_EN_BIT];
   // write lands on the edge where the master sees pready high
   assign wr_go = ce & psel & penable & pwrite & pready;
   // read data loaded one edge early so it stands when pready rises
   assign rd_go = ce & psel & penable & ~pready;

   // ***********************************************************
   // start-of-packet qualification
   // ***********************************************************
   logic inframe_last_r;
   logic [15:0] sop_bits;
   logic [SLOTS-1:0] qual;
   logic [SLOTS-1:0] hit;

   // a start is a frame bit rising against the previous lane
   assign sop_bits = tx_mac_inframe & ~{tx_mac_inframe[14:0], inframe_last_r};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inframe_last_r <= 1'b0;
      end else if (ce && tx_mac_valid) begin
         inframe_last_r <= tx_mac_inframe[15];
      end
   end

   always_comb begin
      qual[0] = enable & (seg_mode ? (tx_mac_valid & (|sop_bits[7:0]))
                                   : (tx_valid & tx_startofpacket)); // R6
      qual[1] = enable & seg_mode & tx_mac_valid & (|sop_bits[15:8]); // R7
      // skip-crc packets get no correction: the crc would go stale
      hit = (peer_delay_add_req | asym_delay_add_req) & ~{SLOTS{tx_skip_crc}};
   end

   // ***********************************************************
   // table and per-slot pipeline
   // ***********************************************************
   logic [SLOTS-1:0] s1_valid_r;
   logic [SLOTS-1:0] s1_p2p_r;
   logic [SLOTS-1:0] s1_asym_r;
   logic [SLOTS-1:0] s1_sign_r;
   logic [SLOTS*IDX_W-1:0] s1_idx_r;
   logic [SLOTS*2*DW-1:0] tbl_rdata;
   logic [1:0] tbl_we;

   assign tbl_we = {wr_go & (paddr == OFS_TBL_ASYM),
                    wr_go & (paddr == OFS_TBL_P2P)};

   delay_table_mem #(.DW(DW), .AW(IDX_W), .NRD(SLOTS)) u_tbl (
      .pclk(pclk),
      .ce(ce),
      .waddr(tbl_addr_r),
      .we(tbl_we),
      .wdata(pwdata[DW-1:0]),
      .raddr(delay_table_index), // R4
      .rdata(tbl_rdata)
   );

   for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      logic [DW2-1:0] asym_ext;
      logic [DW2-1:0] p2p_ext;

      assign p2p_ext = {2'b00, tbl_rdata[s*2*DW +: DW]};
      assign asym_ext = {2'b00, tbl_rdata[s*2*DW+DW +: DW]};

      // controls taken only on the qualifying start, held otherwise
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_valid_r[s] <= 1'b0;
            s1_p2p_r[s] <= 1'b0;
            s1_asym_r[s] <= 1'b0;
            s1_sign_r[s] <= 1'b0;
            s1_idx_r[s*IDX_W +: IDX_W] <= '0;
         end else if (ce) begin
            s1_valid_r[s] <= qual[s] & hit[s]; // R13
            if (qual[s]) begin
               s1_p2p_r[s] <= peer_delay_add_req[s]; // R6 R7
               s1_asym_r[s] <= asym_delay_add_req[s]; // R9 R10
               s1_sign_r[s] <= asym_delay_sign[s]; // R11
               s1_idx_r[s*IDX_W +: IDX_W] <=
                  delay_table_index[s*IDX_W +: IDX_W]; // R12
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            corr_valid[s] <= 1'b0;
            corr_delta[s*DW2 +: DW2] <= '0;
         end else if (ce) begin
            corr_valid[s] <= s1_valid_r[s];
            corr_delta[s*DW2 +: DW2] <=
               (s1_p2p_r[s] ? p2p_ext : '0) + // R1
               (s1_asym_r[s] ? (s1_sign_r[s] ? -asym_ext : asym_ext)
                             : '0); // R2 R3
         end
      end

      property p_cap;
         @(posedge pclk) disable iff (!presetn)
         (ce && qual[s] && hit[s]) ##1 ce |=> corr_valid[s];
      endproperty
      a_cap: assert property (p_cap) // R13
         else $error("qualified request gave no correction");

      property p_noqual;
         @(posedge pclk) disable iff (!presetn)
         (ce && !qual[s]) ##1 ce |=> !corr_valid[s];
      endproperty
      a_noqual: assert property (p_noqual) // R13
         else $error("correction without a qualified start");

      property p_p2p_only;
         @(posedge pclk) disable iff (!presetn)
         (ce && s1_valid_r[s] && s1_p2p_r[s] && !s1_asym_r[s])
         |=> corr_delta[s*DW2 +: DW2] == $past(p2p_ext);
      endproperty
      a_p2p_only: assert property (p_p2p_only) // R1
         else $error("peer delay not added");

      property p_asym_pos;
         @(posedge pclk) disable iff (!presetn)
         (ce && s1_valid_r[s] && !s1_p2p_r[s] && s1_asym_r[s] &&
          !s1_sign_r[s]) |=> corr_delta[s*DW2 +: DW2] == $past(asym_ext);
      endproperty
      a_asym_pos: assert property (p_asym_pos) // R2
         else $error("positive asymmetry not added");

      property p_asym_neg;
         @(posedge pclk) disable iff (!presetn)
         (ce && s1_valid_r[s] && !s1_p2p_r[s] && s1_asym_r[s] &&
          s1_sign_r[s])
         |=> corr_delta[s*DW2 +: DW2] + $past(asym_ext) == '0;
      endproperty
      a_asym_neg: assert property (p_asym_neg) // R3
         else $error("negative asymmetry not subtracted");

      property p_idx;
         @(posedge pclk) disable iff (!presetn)
         (ce && qual[s]) |=> s1_idx_r[s*IDX_W +: IDX_W] ==
            $past(delay_table_index[s*IDX_W +: IDX_W]);
      endproperty
      a_idx: assert property (p_idx) // R12
         else $error("index not captured at start");
   end

   property p_seg_slot1;
      @(posedge pclk) disable iff (!presetn)
      (ce && !seg_mode) |-> !qual[1];
   endproperty
   a_seg_slot1: assert property (p_seg_slot1) // R7
      else $error("second slot qualified in streaming mode");

   property p_stream;
      @(posedge pclk) disable iff (!presetn)
      (ce && enable && !seg_mode && tx_valid && tx_startofpacket &&
       asym_delay_add_req[0] && !tx_skip_crc) ##1 ce
      |=> corr_valid[0];
   endproperty
   a_stream: assert property (p_stream) // R9
      else $error("streaming asymmetry request lost");

   property p_skip;
      @(posedge pclk) disable iff (!presetn)
      (ce && tx_skip_crc && (|(qual & (peer_delay_add_req |
       asym_delay_add_req)))) |=> viol_r ##1 (!ce || !(|corr_valid));
   endproperty
   a_skip: assert property (p_skip) // R8
      else $error("skip-crc request not flagged or not dropped");

   // ***********************************************************
   // status capture
   // ***********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         viol_r <= 1'b0;
      end else if (ce) begin
         // new violation wins over a write-one clear in the same cycle
         viol_r <= (tx_skip_crc & (|(qual & (peer_delay_add_req |
                    asym_delay_add_req)))) | // R8
                   (viol_r & ~(wr_go & (paddr == OFS_STATUS) &
                    pwdata[STATUS_VIOL_BIT]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_idx_r <= TBL_ADDR_RST;
         pkt_cnt_r <= CNT_RST;
      end else if (ce) begin
         if (qual[0]) begin
            last_idx_r <= delay_table_index[IDX_W-1:0];
         end
         // wraps; software takes differences
         pkt_cnt_r <= pkt_cnt_r + CNT_W'(s1_valid_r[0]) +
                      CNT_W'(s1_valid_r[1]);
      end
   end

   // ***********************************************************
   // apb slave
   // ***********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         tbl_addr_r <= TBL_ADDR_RST;
      end else if (wr_go) begin
         if (paddr == OFS_CTRL) begin
            ctrl_r <= pwdata[1:0];
         end
         if (paddr == OFS_TBL_ADDR) begin
            tbl_addr_r <= pwdata[IDX_W-1:0];
         end
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
      unique case (paddr)
         OFS_CTRL: rd_nxt = {30'h0000_0000, ctrl_r};
         OFS_STATUS: rd_nxt = {pkt_cnt_r, 1'b0, last_idx_r, 7'h00, viol_r};
         OFS_TBL_ADDR: rd_nxt = {25'h000_0000, tbl_addr_r};
         // table words are write-only and read as zero
         OFS_TBL_ASYM, OFS_TBL_P2P: rd_nxt = 32'h0000_0000;
         default: err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         if (rd_go) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= err_nxt;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule

// ==== tb/tx_client.sv ====
// transmit client model: presents one packet start with its controls
// assumes send() is called just after a rising pclk edge
`timescale 1ns/1ns
module tx_client (
   input wire logic pclk,
   output logic tx_valid,
   output logic tx_startofpacket,
   output logic tx_mac_valid,
   output logic [15:0] tx_mac_inframe,
   output logic tx_skip_crc,
   output logic [1:0] peer_delay_add_req,
   output logic [1:0] asym_delay_add_req,
   output logic [1:0] asym_delay_sign,
   output logic [13:0] delay_table_index
);
   initial begin
      tx_valid = 1'b0;
      tx_startofpacket = 1'b0;
      tx_mac_valid = 1'b0;
      tx_mac_inframe = 16'h0000;
      tx_skip_crc = 1'b0;
      peer_delay_add_req = 2'h0;
      asym_delay_add_req = 2'h0;
      asym_delay_sign = 2'h0;
      delay_table_index = 14'h0000;
   end
   // ***********************************************************
   // one start cycle, then idle
   // ***********************************************************
   task automatic send(input logic seg, sop, input logic [15:0] fr,
      input logic [1:0] p, a, s, input logic [13:0] ix, input logic sk);
      @(posedge pclk);
      tx_valid <= !seg;
      tx_startofpacket <= !seg && sop;
      tx_mac_valid <= seg;
      tx_mac_inframe <= seg ? fr : 16'h0000;
      tx_skip_crc <= sk;
      peer_delay_add_req <= p;
      asym_delay_add_req <= a;
      asym_delay_sign <= s;
      delay_table_index <= ix;
      @(posedge pclk);
      tx_valid <= 1'b0;
      tx_startofpacket <= 1'b0;
      tx_mac_valid <= 1'b0;
      tx_skip_crc <= 1'b0;
      // controls are meaningless now: show inverse, never stale values
      peer_delay_add_req <= ~p;
      asym_delay_add_req <= ~a;
      asym_delay_sign <= ~s;
      delay_table_index <= ~ix;
   endtask
endmodule

// ==== tb/tb_ptp_corr_ctl.sv ====
// bench for the correction-delay controls: apb master plus client model
// assumes one pclk domain and ce held high
`timescale 1ns/1ns
module tb_ptp_corr_ctl;
   import ptp_corr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic tx_valid, tx_startofpacket, tx_mac_valid, tx_skip_crc, er;
   logic [15:0] tx_mac_inframe;
   logic [1:0] peer_delay_add_req, asym_delay_add_req, asym_delay_sign;
   logic [1:0] corr_valid;
   logic [13:0] delay_table_index;
   logic [67:0] corr_delta;
   logic [31:0] p2p_t [128];
   logic [31:0] asym_t [128];
   int num_errors = 0;
   int n_tests = 0;
   ptp_corr_ctl dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_valid(tx_valid),
      .tx_startofpacket(tx_startofpacket), .tx_mac_valid(tx_mac_valid),
      .tx_mac_inframe(tx_mac_inframe), .tx_skip_crc(tx_skip_crc),
      .peer_delay_add_req(peer_delay_add_req),
      .asym_delay_add_req(asym_delay_add_req),
      .asym_delay_sign(asym_delay_sign),
      .delay_table_index(delay_table_index),
      .corr_valid(corr_valid), .corr_delta(corr_delta));
   tx_client client (.pclk(pclk), .tx_valid(tx_valid),
      .tx_startofpacket(tx_startofpacket), .tx_mac_valid(tx_mac_valid),
      .tx_mac_inframe(tx_mac_inframe), .tx_skip_crc(tx_skip_crc),
      .peer_delay_add_req(peer_delay_add_req),
      .asym_delay_add_req(asym_delay_add_req),
      .asym_delay_sign(asym_delay_sign),
      .delay_table_index(delay_table_index));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic chk(input string nm, input logic [33:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic load(input logic [6:0] i, input logic [31:0] p, a);
      p2p_t[i] = p;
      asym_t[i] = a;
      apb(1'b1, OFS_TBL_ADDR, {25'h0, i}, rd, er);
      apb(1'b1, OFS_TBL_P2P, p, rd, er);
      apb(1'b1, OFS_TBL_ASYM, a, rd, er);
   endtask
   function automatic logic [33:0] ed(logic p, a, s, logic [6:0] i);
      logic [33:0] pv, av;
      pv = p ? {2'h0, p2p_t[i]} : 34'h0;
      av = a ? {2'h0, asym_t[i]} : 34'h0;
      return s ? pv - av : pv + av;
   endfunction
   // correction stands only in the second cycle after the start cycle
   task automatic pkt(input logic seg, sop, input logic [15:0] fr,
      input logic [1:0] p, a, s, input logic [13:0] ix,
      input logic sk, input logic [1:0] ev);
      client.send(seg, sop, fr, p, a, s, ix, sk);
      repeat (PIPE_LAT - 1) @(posedge pclk);
      #1;
      chk("corr_valid", {32'h0, corr_valid}, {32'h0, ev});
      for (int k = 0; k < 2; k++) begin
         if (ev[k]) begin
            chk("corr_delta", corr_delta[k*34 +: 34],
               ed(p[k], a[k], s[k], ix[k*7 +: 7]));
         end
      end
      @(posedge pclk);
      #1;
      chk("corr_valid_end", {32'h0, corr_valid}, 34'h0);
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      wrap_up;
   end
   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0, rd, er);
      chk("ctrl_reset", {2'h0, rd}, 34'h0);
      chk("ctrl_err", {33'h0, er}, 34'h0);
      apb(1'b0, 8'h40, 32'h0, rd, er);
      chk("unmapped_err", {33'h0, er}, 34'h1);
      chk("unmapped_data", {2'h0, rd}, 34'h0);
      load(7'h05, 32'h00001200, 32'h00000340);
      load(7'h09, 32'h00000a00, 32'h00000077);
      load(7'h7f, 32'hfffff000, 32'h00012345);
      pkt(1'b0, 1'b1, 16'h0, 2'h1, 2'h0, 2'h0, 14'h5, 1'b0, 2'h0);
      apb(1'b1, OFS_CTRL, 32'h2, rd, er);
      pkt(1'b0, 1'b1, 16'h0, 2'h1, 2'h0, 2'h0, 14'h5, 1'b0, 2'h1);
      pkt(1'b0, 1'b1, 16'h0, 2'h0, 2'h1, 2'h0, 14'h9, 1'b0, 2'h1);
      pkt(1'b0, 1'b1, 16'h0, 2'h1, 2'h1, 2'h1, 14'h7f, 1'b0, 2'h1);
      pkt(1'b0, 1'b1, 16'h0, 2'h0, 2'h1, 2'h1, 14'h9, 1'b0, 2'h1);
      pkt(1'b0, 1'b0, 16'h0, 2'h3, 2'h3, 2'h0, 14'h5, 1'b0, 2'h0);
      pkt(1'b0, 1'b1, 16'h0, 2'h1, 2'h1, 2'h0, 14'h5, 1'b1, 2'h0);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk("status_viol", {33'h0, rd[STATUS_VIOL_BIT]}, 34'h1);
      chk("status_count", {18'h0, rd[31:16]}, 34'h4);
      chk("status_idx", {27'h0, rd[STATUS_IDX_LSB +: IDX_W]}, 34'h5);
      apb(1'b1, OFS_STATUS, 32'h1, rd, er);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      chk("status_clear", {33'h0, rd[STATUS_VIOL_BIT]}, 34'h0);
      apb(1'b1, OFS_CTRL, 32'h3, rd, er);
      pkt(1'b1, 1'b0, 16'h0f0f, 2'h3, 2'h2, 2'h2, {7'h9, 7'h5}, 1'b0,
         2'h3);
      pkt(1'b1, 1'b0, 16'h0f00, 2'h2, 2'h2, 2'h0, {7'h7f, 7'h9}, 1'b0,
         2'h2);
      wrap_up;
   end
endmodule
